// >>> core/sdr_pkg.sv
/*
 register map, field positions, reset values and timing constants
 of the synthesizer configuration register slice.
 assumes a 32-bit AHB-Lite register bus, one register per word.
*/
package sdr_pkg;

    // register indices; byte address is four times the index
    localparam logic [4:0] IDX_STATUS    = 5'h00;
    localparam logic [4:0] IDX_MODE_TWO  = 5'h01;
    localparam logic [4:0] IDX_PLL_CFG   = 5'h02;
    localparam logic [4:0] IDX_SYNC_CAL  = 5'h03;
    localparam logic [4:0] IDX_RAMP_LOW  = 5'h04;
    localparam logic [4:0] IDX_RAMP_HIGH = 5'h05;
    localparam logic [4:0] IDX_RAMP_RISE = 5'h06;
    localparam logic [4:0] IDX_IRQ_STAT  = 5'h1C;
    localparam logic [4:0] IDX_IRQ_MASK  = 5'h1D;

    // status register
    localparam int LOCK_BIT     = 24;
    // mode_control_two
    localparam int RAMP_EN_BIT  = 19;
    // pll_loop_config fields
    localparam int FB_DIV_LSB   = 8;
    localparam int FB_DIV_MSB   = 15;
    localparam int PUMP_MAN_BIT = 6;
    localparam int PUMP_LSB     = 3;
    localparam int PUMP_MSB     = 5;
    localparam int LOCK_EN_BIT  = 2;
    localparam int LDW_LSB      = 0;
    localparam int LDW_MSB      = 1;
    localparam logic [31:0] PLL_CFG_MASK = 32'h0000FF7F;
    localparam logic [7:0]  FB_DIV_RST   = 8'h19;
    localparam logic [7:0]  FB_DIV_MIN   = 8'h0A;
    // sync_and_dac_cal_control fields
    localparam int AUX_PD_BIT   = 26;
    localparam int CALCLK_PD_BIT = 25;
    localparam int CAL_EN_BIT   = 24;
    localparam logic [31:0] SYNC_CAL_MASK = 32'h07FFFFFF;
    localparam logic [23:0] SYNC_CAL_LOW_RST = 24'h000000;

    // lock window lengths in reference-clock cycles
    localparam logic [10:0] LDW_128  = 11'h080;
    localparam logic [10:0] LDW_256  = 11'h100;
    localparam logic [10:0] LDW_512  = 11'h200;
    localparam logic [10:0] LDW_1024 = 11'h400;

    // interrupt status bits
    localparam int IRQ_LOCK_GAIN = 0;
    localparam int IRQ_LOCK_LOSS = 1;
    localparam int IRQ_CAL_DONE  = 2;
    localparam int IRQ_W         = 3;

    // dac calibration length
    localparam int CAL_TIME_NS   = 1600;
    localparam int CLK_PERIOD_NS = 25;
    localparam int CAL_CYCLES    = CAL_TIME_NS / CLK_PERIOD_NS;

    // ahb-lite
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

endpackage

// >>> core/sdr_regs.sv
/*
 configuration register slice: pll loop config, sync/dac calibration
 control, ramp limits and rising step, lock detector, calibration
 sequencer and interrupt logic, reached over AHB-Lite.
 assumes mclk at 40 MHz, synchronous active-high rst, ref_tick one
 mclk pulse per reference cycle, all inputs synchronous to mclk.
*/
// Chosen here: register access over AHB-Lite.
// Function
// - bits 15:8 hold divider N; total pll multiplication is 2N, N 10..255
// - divider field resets to 25, giving total multiplication of 50
// - bit 6 zero: calibration picks pump current; one: bits 5:3 used
// - bit 2 of pll config enables lock detection
// - lock window field selects 128, 256, 512 or 1024 in-bound cycles
// - lock reported as status bit 24 of register 0x00
// - bit 26 of 0x03 zero enables sync output, one disables it
// - calibration clock runs only when bits 25 and 26 are both zero
// - writing one to bit 24 of 0x03 starts dac calibration
// - register 0x04 holds 32-bit ramp lower limit
// - register 0x05 holds 32-bit ramp upper limit
// - register 0x06 holds 32-bit rising ramp step size
// - ramp registers take effect only while 0x01 bit 19 is one
`timescale 1ns/1ps
`default_nettype none
module sdr_regs
    import sdr_pkg::*;
#(
    parameter int CAL_LEN = sdr_pkg::CAL_CYCLES
)(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // phase detector
    input  wire logic        ref_tick,
    input  wire logic        phase_detector_in_window,
    // pll controls
    output logic [7:0]       fb_div_n,
    output logic [8:0]       pll_mult,
    output logic             pump_current_manual_select,
    output logic [2:0]       pump_current_setting,
    output logic             pll_locked,
    // sync output and dac calibration
    output logic             sync_out_en,
    output logic             dac_cal_clk_en,
    output logic             dac_cal_busy,
    // ramp generator
    output logic             ramp_en,
    output logic [31:0]      ramp_low_eff,
    output logic [31:0]      ramp_high_eff,
    output logic [31:0]      ramp_rise_eff,
    // interrupt
    output logic             irq
);
    import sdr_pkg::*;

    typedef enum logic [1:0] {SDR_IDLE, SDR_RUN, SDR_DONE} sdr_cal_t;

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [31:0]      mode_two_r;
    logic [31:0]      pll_cfg_r;
    logic [31:0]      sync_cal_r;
    logic [31:0]      ramp_low_bound_r;
    logic [31:0]      ramp_high_bound_r;
    logic [31:0]      ramp_rise_increment_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [31:0]      hrdata_r;
    logic             wr_pend_r;
    logic [4:0]       wr_idx_r;
    logic [10:0]      lock_cnt_r;
    logic             lock_r;
    sdr_cal_t         cal_st_r;
    sdr_cal_t         cal_st_nxt;
    logic [15:0]      cal_cnt_r;
    logic [31:0]      ramp_low_r;
    logic [31:0]      ramp_high_r;
    logic [31:0]      ramp_rise_r;

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    function automatic logic is_word_addr(input logic [31:0] a);
        is_word_addr = (a[1:0] == 2'h0) && (a[31:7] == 25'h0);
    endfunction

    wire        addr_ok  = hsel && hready && (htrans == HTRANS_NONSEQ)
                           && (hsize == HSIZE_WORD) && is_word_addr(haddr);
    wire        wr_start = addr_ok && hwrite;
    wire        rd_start = addr_ok && !hwrite;
    wire [4:0]  a_idx    = haddr[6:2];

    wire        wr_pll   = wr_pend_r && (wr_idx_r == IDX_PLL_CFG);
    wire        wr_sync  = wr_pend_r && (wr_idx_r == IDX_SYNC_CAL);
    wire        wr_mode  = wr_pend_r && (wr_idx_r == IDX_MODE_TWO);
    wire        wr_low   = wr_pend_r && (wr_idx_r == IDX_RAMP_LOW);
    wire        wr_high  = wr_pend_r && (wr_idx_r == IDX_RAMP_HIGH);
    wire        wr_rise  = wr_pend_r && (wr_idx_r == IDX_RAMP_RISE);
    wire        wr_istat = wr_pend_r && (wr_idx_r == IDX_IRQ_STAT);
    wire        wr_imask = wr_pend_r && (wr_idx_r == IDX_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////
    // write values

    wire [7:0]  wr_n      = hwdata[FB_DIV_MSB:FB_DIV_LSB];
    wire        wr_n_ok   = (wr_n >= FB_DIV_MIN);
    wire [7:0]  n_keep    = wr_n_ok ? wr_n
                                    : pll_cfg_r[FB_DIV_MSB:FB_DIV_LSB];
    wire [31:0] pll_wval  = {16'h0000, n_keep, hwdata[7:0]}
                            & PLL_CFG_MASK;
    wire [31:0] sync_wval = hwdata & SYNC_CAL_MASK
                            & ~(32'h1 << CAL_EN_BIT);
    wire [31:0] mode_wval = hwdata & (32'h1 << RAMP_EN_BIT);

    wire        cal_start = wr_sync && hwdata[CAL_EN_BIT];
    wire        cal_clk   = !sync_cal_r[CALCLK_PD_BIT]
                            && !sync_cal_r[AUX_PD_BIT];

    ////////////////////////////////////////////////////////////////////////
    // read mux

    wire [31:0] status_val = {7'h00, lock_r, 24'h000000};
    wire [31:0] sync_rval  = {sync_cal_r[31:25], (cal_st_r == SDR_RUN),
                              sync_cal_r[23:0]};
    logic [31:0] rd_val;

    always_comb
    begin
        case (a_idx)
            IDX_STATUS:    rd_val = status_val;
            IDX_MODE_TWO:  rd_val = mode_two_r;
            IDX_PLL_CFG:   rd_val = pll_cfg_r;
            IDX_SYNC_CAL:  rd_val = sync_rval;
            IDX_RAMP_LOW:  rd_val = ramp_low_bound_r;
            IDX_RAMP_HIGH: rd_val = ramp_high_bound_r;
            IDX_RAMP_RISE: rd_val = ramp_rise_increment_r;
            IDX_IRQ_STAT:  rd_val = {29'h0, irq_stat_r};
            IDX_IRQ_MASK:  rd_val = {29'h0, irq_mask_r};
            default:       rd_val = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // bus phase tracking

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 5'h00;
            hrdata_r  <= 32'h00000000;
        end
        else
        begin
            wr_pend_r <= wr_start;
            wr_idx_r  <= a_idx;
            if (rd_start)
                hrdata_r <= rd_val;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pll_cfg_r  <= {16'h0000, FB_DIV_RST, 8'h00};
            sync_cal_r <= {8'h00, SYNC_CAL_LOW_RST};
            mode_two_r <= 32'h00000000;
        end
        else
        begin
            if (wr_pll)
                pll_cfg_r <= pll_wval;
            if (wr_sync)
                sync_cal_r <= sync_wval;
            if (wr_mode)
                mode_two_r <= mode_wval;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ramp_low_bound_r      <= 32'h00000000;
            ramp_high_bound_r     <= 32'h00000000;
            ramp_rise_increment_r <= 32'h00000000;
        end
        else
        begin
            if (wr_low)
                ramp_low_bound_r <= hwdata;
            if (wr_high)
                ramp_high_bound_r <= hwdata;
            if (wr_rise)
                ramp_rise_increment_r <= hwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lock detector

    wire [1:0]  ldw_sel  = pll_cfg_r[LDW_MSB:LDW_LSB];
    wire        lock_en  = pll_cfg_r[LOCK_EN_BIT];
    wire [10:0] ldw_len  = (ldw_sel == 2'h0) ? LDW_128 :
                           (ldw_sel == 2'h1) ? LDW_256 :
                           (ldw_sel == 2'h2) ? LDW_512 : LDW_1024;
    wire        lock_hit = ref_tick && phase_detector_in_window
                           && (lock_cnt_r + 11'h001 >= ldw_len);
    wire        lock_drop = ref_tick && !phase_detector_in_window;
    wire        lock_gain_ev = lock_en && lock_hit && !lock_r;
    wire        lock_loss_ev = lock_r && (!lock_en || lock_drop);

    always_ff @(posedge mclk)
    begin
        if (rst || !lock_en)
        begin
            lock_cnt_r <= 11'h000;
            lock_r     <= 1'b0;
        end
        else if (lock_drop)
        begin
            lock_cnt_r <= 11'h000;
            lock_r     <= 1'b0;
        end
        else if (lock_hit)
        begin
            lock_cnt_r <= ldw_len;
            lock_r     <= 1'b1;
        end
        else if (ref_tick && phase_detector_in_window)
            lock_cnt_r <= lock_cnt_r + 11'h001;
    end

    ////////////////////////////////////////////////////////////////////////
    // dac calibration sequencer

    wire [15:0] cal_last = 16'(CAL_LEN - 1);

    always_comb
    begin
        case (cal_st_r)
            SDR_IDLE: cal_st_nxt = cal_start ? SDR_RUN : SDR_IDLE;
            SDR_RUN:  cal_st_nxt = (cal_clk && cal_cnt_r == cal_last)
                                   ? SDR_DONE : SDR_RUN;
            SDR_DONE: cal_st_nxt = SDR_IDLE;
            default:  cal_st_nxt = SDR_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cal_st_r  <= SDR_IDLE;
            cal_cnt_r <= 16'h0000;
        end
        else
        begin
            cal_st_r <= cal_st_nxt;
            if (cal_st_r != SDR_RUN)
                cal_cnt_r <= 16'h0000;
            else if (cal_clk)
                cal_cnt_r <= cal_cnt_r + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ramp parameters

    always_ff @(posedge mclk)
    begin
        if (rst || !mode_two_r[RAMP_EN_BIT])
        begin
            ramp_low_r  <= 32'h00000000;
            ramp_high_r <= 32'h00000000;
            ramp_rise_r <= 32'h00000000;
        end
        else
        begin
            ramp_low_r  <= ramp_low_bound_r;
            ramp_high_r <= ramp_high_bound_r;
            ramp_rise_r <= ramp_rise_increment_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts

    wire [IRQ_W-1:0] irq_ev  = {(cal_st_r == SDR_DONE), lock_loss_ev,
                                lock_gain_ev};
    wire [IRQ_W-1:0] irq_clr = wr_istat ? hwdata[IRQ_W-1:0]
                                        : {IRQ_W{1'b0}};

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            irq_stat_r <= {IRQ_W{1'b0}};
            irq_mask_r <= {IRQ_W{1'b0}};
        end
        else
        begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
            if (wr_imask)
                irq_mask_r <= hwdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign fb_div_n                   = pll_cfg_r[FB_DIV_MSB:FB_DIV_LSB];
    assign pll_mult                   = {fb_div_n, 1'b0};
    assign pump_current_manual_select = pll_cfg_r[PUMP_MAN_BIT];
    assign pump_current_setting       = pll_cfg_r[PUMP_MSB:PUMP_LSB];
    assign pll_locked                 = lock_r;
    assign sync_out_en                = !sync_cal_r[AUX_PD_BIT];
    assign dac_cal_clk_en             = cal_clk;
    assign dac_cal_busy               = (cal_st_r == SDR_RUN);
    assign ramp_en                    = mode_two_r[RAMP_EN_BIT];
    assign ramp_low_eff               = ramp_low_r;
    assign ramp_high_eff              = ramp_high_r;
    assign ramp_rise_eff              = ramp_rise_r;

endmodule
`default_nettype wire

// >>> test/sdr_regs_monitor.sv
/*
 checker on the register slice ports.
 assumes it is bound into sdr_regs.
*/
`timescale 1ns/1ps
`default_nettype none
module sdr_regs_monitor
    import sdr_pkg::*;
#(
    parameter int CAL_LEN = sdr_pkg::CAL_CYCLES
)(
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // watched ports
    input wire logic        ref_tick,
    input wire logic        phase_detector_in_window,
    input wire logic [7:0]  fb_div_n,
    input wire logic [8:0]  pll_mult,
    input wire logic        pll_locked,
    input wire logic        sync_out_en,
    input wire logic        dac_cal_clk_en,
    input wire logic        dac_cal_busy,
    input wire logic        ramp_en,
    input wire logic [31:0] ramp_low_eff
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // clocked calibration cycles of the current run
    logic [15:0] run_cnt;
    always_ff @(posedge mclk)
    begin
        if (rst || !dac_cal_busy)
            run_cnt <= 16'h0000;
        else if (dac_cal_clk_en)
            run_cnt <= run_cnt + 16'h0001;
    end
    ////////////////////////////////////////
    property p_mult; pll_mult == {fb_div_n, 1'b0}; endproperty
    a_mult: assert property (p_mult) else $error("bad 2N");
    property p_rstn; $fell(rst) |-> fb_div_n == FB_DIV_RST; endproperty
    a_rstn: assert property (p_rstn) else $error("bad reset N");
    property p_lock;
        $rose(pll_locked) |-> $past(ref_tick && phase_detector_in_window);
    endproperty
    a_lock: assert property (p_lock) else $error("lock w/o tick");
    property p_drop;
        ref_tick && !phase_detector_in_window |=> !pll_locked;
    endproperty
    a_drop: assert property (p_drop) else $error("lock kept");
    property p_clk; dac_cal_clk_en |-> sync_out_en; endproperty
    a_clk: assert property (p_clk) else $error("cal clock on");
    property p_hold; dac_cal_busy && !dac_cal_clk_en |=> dac_cal_busy;
    endproperty
    a_hold: assert property (p_hold) else $error("cal ran");
    property p_len; $rose(dac_cal_busy) |-> dac_cal_busy[*8]; endproperty
    a_len: assert property (p_len) else $error("cal short");
    property p_run; $fell(dac_cal_busy) |-> run_cnt == 16'(CAL_LEN);
    endproperty
    a_run: assert property (p_run) else $error("cal length");
    property p_ramp;
        !ramp_en && !$past(ramp_en) |-> ramp_low_eff == 32'h0;
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp used");
    c_lock: cover property ($rose(pll_locked));
    c_cal: cover property ($fell(dac_cal_busy));
    c_ramp: cover property ($rose(ramp_en));
    c_hold: cover property (dac_cal_busy && !dac_cal_clk_en);
endmodule
bind sdr_regs sdr_regs_monitor #(.CAL_LEN(CAL_LEN)) i_mon (
    .mclk                     (mclk),
    .rst                      (rst),
    .ref_tick                 (ref_tick),
    .phase_detector_in_window (phase_detector_in_window),
    .fb_div_n                 (fb_div_n),
    .pll_mult                 (pll_mult),
    .pll_locked               (pll_locked),
    .sync_out_en              (sync_out_en),
    .dac_cal_clk_en           (dac_cal_clk_en),
    .dac_cal_busy             (dac_cal_busy),
    .ramp_en                  (ramp_en),
    .ramp_low_eff             (ramp_low_eff)
);
`default_nettype wire

// >>> test/sdr_host.sv
/*
 host controller model: ahb-lite master, single word transfers.
 assumes hready is the slave's hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
module sdr_host
    import sdr_pkg::*;
(
    // clock
    input wire logic        mclk,
    // ahb-lite master
    output logic            hsel = 1'b0,
    output logic [31:0]     haddr = 32'h0,
    output logic [1:0]      htrans = 2'h0,
    output logic            hwrite = 1'b0,
    output logic [2:0]      hsize = 3'h2,
    output logic [31:0]     hwdata = 32'h0,
    input wire logic        hready,
    input wire logic [31:0] hrdata
);
    ////////////////////////////////////////
    task automatic xfer(input logic [31:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        do @(posedge mclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
        @(posedge mclk);
    endtask
    // calibration start, low bits at defaults
    task automatic cal_start();
        wr(32'h0000_000C, 32'h0100_0000);
    endtask
endmodule
`default_nettype wire

// >>> test/tb.sv
/*
 bench: host model on the bus, bench drives the phase detector.
 assumes package, design, host model and checker compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sdr_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        ref_tick = 1'b0;
    logic        phase_detector_in_window = 1'b0;
    logic        hsel, hwrite, hready, hreadyout, hresp, irq, ramp_en;
    logic        pll_locked, pump_current_manual_select, sync_out_en;
    logic        dac_cal_clk_en, dac_cal_busy;
    logic [1:0]  htrans;
    logic [2:0]  hsize, pump_current_setting;
    logic [7:0]  fb_div_n;
    logic [8:0]  pll_mult;
    logic [31:0] haddr, hwdata, hrdata, ramp_low_eff, ramp_high_eff;
    logic [31:0] ramp_rise_eff;
    int          err_total = 0;
    int          num_checks = 0;
    assign hready = hreadyout;
    always #12.5 mclk = ~mclk;
    sdr_regs #(.CAL_LEN(8)) i_dut (
        .mclk                       (mclk),
        .rst                        (rst),
        .hsel                       (hsel),
        .haddr                      (haddr),
        .htrans                     (htrans),
        .hwrite                     (hwrite),
        .hsize                      (hsize),
        .hwdata                     (hwdata),
        .hready                     (hready),
        .hreadyout                  (hreadyout),
        .hrdata                     (hrdata),
        .hresp                      (hresp),
        .ref_tick                   (ref_tick),
        .phase_detector_in_window   (phase_detector_in_window),
        .fb_div_n                   (fb_div_n),
        .pll_mult                   (pll_mult),
        .pump_current_manual_select (pump_current_manual_select),
        .pump_current_setting       (pump_current_setting),
        .pll_locked                 (pll_locked),
        .sync_out_en                (sync_out_en),
        .dac_cal_clk_en             (dac_cal_clk_en),
        .dac_cal_busy               (dac_cal_busy),
        .ramp_en                    (ramp_en),
        .ramp_low_eff               (ramp_low_eff),
        .ramp_high_eff              (ramp_high_eff),
        .ramp_rise_eff              (ramp_rise_eff),
        .irq                        (irq)
    );
    sdr_host i_host (
        .mclk   (mclk),
        .hsel   (hsel),
        .haddr  (haddr),
        .htrans (htrans),
        .hwrite (hwrite),
        .hsize  (hsize),
        .hwdata (hwdata),
        .hready (hready),
        .hrdata (hrdata)
    );
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        i_host.xfer(a, 1'b0, 32'h0, q);
        chk(q, e);
    endtask
    task automatic tick(input int n, input logic w);
        repeat (n)
        begin
            ref_tick <= 1'b1;
            phase_detector_in_window <= w;
            @(posedge mclk);
            ref_tick <= 1'b0;
            @(posedge mclk);
        end
    endtask
    task automatic wait_busy(input logic v);
        for (int i = 0; i < 30 && dac_cal_busy !== v; i++)
            @(posedge mclk);
        chk(dac_cal_busy, {31'h0, v});
    endtask
    ////////////////////////////////////////
    task automatic t_pll();
        chk({fb_div_n, pll_mult}, {8'h19, 9'h032});
        rchk(32'h8, 32'h0000_1900);
        chk({sync_out_en, dac_cal_clk_en}, 32'h3);
        i_host.wr(32'h8, 32'hFFFF_FFFF);
        rchk(32'h8, 32'h0000_FF7F);
        chk({pump_current_manual_select, pump_current_setting}, 32'hF);
        i_host.wr(32'h8, 32'h0000_0945);
        rchk(32'h8, 32'h0000_FF45);
        i_host.wr(32'h8, 32'h0000_0A00);
        chk({pump_current_manual_select, pll_mult}, 32'h014);
        $display("t_pll done");
    endtask
    task automatic t_lock();
        for (int s = 0; s < 4; s++)
        begin
            i_host.wr(32'h8, 32'h0000_1904 | 32'(s));
            tick(1, 1'b0);
            tick((128 << s) - 1, 1'b1);
            chk(pll_locked, 32'h0);
            tick(1, 1'b1);
            chk(pll_locked, 32'h1);
            rchk(32'h0, 32'h0100_0000);
        end
        chk(irq, 32'h0);
        i_host.wr(32'h74, 32'h1);
        chk(irq, 32'h1);
        i_host.wr(32'h70, 32'h7);
        chk(irq, 32'h0);
        tick(1, 1'b0);
        chk(pll_locked, 32'h0);
        i_host.wr(32'h8, 32'h0000_1900);
        tick(128, 1'b1);
        chk(pll_locked, 32'h0);
        $display("t_lock done");
    endtask
    task automatic t_cal();
        i_host.wr(32'h70, 32'h7);
        i_host.cal_start();
        wait_busy(1'b1);
        wait_busy(1'b0);
        rchk(32'h70, 32'h4);
        i_host.wr(32'hC, 32'h0300_0000);
        repeat (20) @(posedge mclk);
        chk({sync_out_en, dac_cal_clk_en, dac_cal_busy}, 32'h5);
        rchk(32'hC, 32'h0300_0000);
        i_host.wr(32'hC, 32'h0400_0000);
        chk({sync_out_en, dac_cal_clk_en}, 32'h0);
        i_host.wr(32'hC, 32'h0);
        wait_busy(1'b0);
        $display("t_cal done");
    endtask
    task automatic t_ramp();
        i_host.wr(32'h10, 32'h1234_5678);
        i_host.wr(32'h14, 32'h9ABC_DEF0);
        i_host.wr(32'h18, 32'h0F0F_A5A5);
        chk(ramp_low_eff | ramp_high_eff | ramp_rise_eff, 32'h0);
        rchk(32'h14, 32'h9ABC_DEF0);
        i_host.wr(32'h4, 32'hFFFF_FFFF);
        rchk(32'h4, 32'h0008_0000);
        chk(ramp_low_eff, 32'h1234_5678);
        chk(ramp_high_eff, 32'h9ABC_DEF0);
        chk(ramp_rise_eff, 32'h0F0F_A5A5);
        i_host.wr(32'h40, 32'hFFFF_FFFF);
        rchk(32'h40, 32'h0);
        chk({ramp_en, hreadyout, hresp}, 32'h6);
        $display("t_ramp done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_pll();
        t_lock();
        t_cal();
        t_ramp();
        print_verdict();
    end
    initial
    begin
        repeat (40000) @(posedge mclk);
        err_total++;
        print_verdict();
    end
endmodule
`default_nettype wire
